// ===== hdl/bsfb_pkg.sv
// bsfb_pkg: register map, command fields, flag positions and opcodes
// of the bit/shift/flag/branch unit; shared by the core and its datapath.
package bsfb_pkg;
	localparam int ADDR_W = 10;
	localparam int OP_W   = 5;
	localparam int DAT_W  = 32;
	// register byte addresses
	localparam logic [ADDR_W-1:0] A_CMD   = 10'h000;
	localparam logic [ADDR_W-1:0] A_KOFF  = 10'h004;
	localparam logic [ADDR_W-1:0] A_PC    = 10'h008;
	localparam logic [ADDR_W-1:0] A_FLAGS = 10'h00C;
	localparam logic [ADDR_W-1:0] A_STAT  = 10'h010;
	// windows: working registers and io registers, one word each
	localparam int                WIN_LSB  = 8;
	localparam logic [1:0]        TAG_WREG = 2'h1;
	localparam logic [1:0]        TAG_IO   = 2'h2;
	// command word fields
	localparam int CMD_OP_LSB  = 0;
	localparam int CMD_IDX_LSB = 8;
	localparam int CMD_BIT_LSB = 16;
	localparam int CMD_IO_LSB  = 24;
	// status word bits
	localparam int ST_BUSY  = 0;
	localparam int ST_LOST  = 1;
	localparam int ST_CYC   = 2;
	localparam int ST_TAKEN = 4;
	// flag positions in the flags register
	localparam logic [2:0] FL_C = 3'h0;
	localparam logic [2:0] FL_Z = 3'h1;
	localparam logic [2:0] FL_N = 3'h2;
	localparam logic [2:0] FL_V = 3'h3;
	localparam logic [2:0] FL_S = 3'h4;
	localparam logic [2:0] FL_H = 3'h5;
	localparam logic [2:0] FL_T = 3'h6;
	localparam logic [2:0] FL_I = 3'h7;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	typedef enum logic [OP_W-1:0] {
		op_nop                         = 5'h00,
		op_branch_no_overflow          = 5'h01,
		op_branch_irq_enabled          = 5'h02,
		op_branch_irq_disabled         = 5'h03,
		op_set_io_bit                  = 5'h04,
		op_clear_io_bit                = 5'h05,
		op_shift_left_logical          = 5'h06,
		op_shift_right_logical         = 5'h07,
		op_rotate_left_carry           = 5'h08,
		op_rotate_right_carry          = 5'h09,
		op_shift_right_arithmetic      = 5'h0A,
		op_swap_nibbles                = 5'h0B,
		op_store_bit_to_transfer_flag  = 5'h0C,
		op_load_bit_from_transfer_flag = 5'h0D,
		op_flag_set                    = 5'h0E,
		op_flag_clear                  = 5'h0F
	} bsfb_op_t;
endpackage : bsfb_pkg

// ===== hdl/bsfb_exec_unit.sv
// bsfb_exec_unit: one-cycle datapath for shifts, rotates, bit moves and
// flag writes. Purely combinational; the core decides what gets stored.
`timescale 1ns/1ps
module bsfb_exec_unit (
	input  wire bsfb_pkg::bsfb_op_t op_i,    // operation
	input  wire logic [7:0]         opnd_i,  // operand register or io value
	input  wire logic [2:0]         bit_i,   // bit or flag select
	input  wire logic [7:0]         flags_i, // current status flags
	output logic      [7:0]         res_o,   // result value
	output logic      [7:0]         flags_o, // next status flags
	output logic                    wr_o     // result is to be stored
);
	logic sh;
	logic cy;
	always_comb begin
		res_o   = opnd_i;
		flags_o = flags_i;
		wr_o    = 1'b0;
		sh      = 1'b0;
		cy      = 1'b0;
		unique case (op_i)
			bsfb_pkg::op_shift_left_logical: begin
				res_o = {opnd_i[6:0], 1'b0};
				cy    = opnd_i[7];
				sh    = 1'b1;
			end
			bsfb_pkg::op_shift_right_logical: begin
				res_o = {1'b0, opnd_i[7:1]};
				cy    = opnd_i[0];
				sh    = 1'b1;
			end
			bsfb_pkg::op_rotate_left_carry: begin
				res_o = {opnd_i[6:0], flags_i[bsfb_pkg::FL_C]};
				cy    = opnd_i[7];
				sh    = 1'b1;
			end
			bsfb_pkg::op_rotate_right_carry: begin
				res_o = {flags_i[bsfb_pkg::FL_C], opnd_i[7:1]};
				cy    = opnd_i[0];
				sh    = 1'b1;
			end
			bsfb_pkg::op_shift_right_arithmetic: begin
				res_o = {opnd_i[7], opnd_i[7:1]};
				cy    = opnd_i[0];
				sh    = 1'b1;
			end
			bsfb_pkg::op_swap_nibbles: begin
				res_o = {opnd_i[3:0], opnd_i[7:4]};
				wr_o  = 1'b1;
			end
			bsfb_pkg::op_store_bit_to_transfer_flag: flags_o[bsfb_pkg::FL_T] = opnd_i[bit_i];
			bsfb_pkg::op_load_bit_from_transfer_flag: begin
				res_o[bit_i] = flags_i[bsfb_pkg::FL_T];
				wr_o         = 1'b1;
			end
			bsfb_pkg::op_flag_set:   flags_o[bit_i] = 1'b1;
			bsfb_pkg::op_flag_clear: flags_o[bit_i] = 1'b0;
			bsfb_pkg::op_set_io_bit:   res_o[bit_i] = 1'b1;
			bsfb_pkg::op_clear_io_bit: res_o[bit_i] = 1'b0;
			default: ;
		endcase
		if (sh) begin
			wr_o                    = 1'b1;
			flags_o[bsfb_pkg::FL_C] = cy;
			flags_o[bsfb_pkg::FL_Z] = (res_o == 8'h00);
			flags_o[bsfb_pkg::FL_N] = res_o[7];
			flags_o[bsfb_pkg::FL_V] = res_o[7] ^ cy;
		end
	end
endmodule : bsfb_exec_unit

// ===== hdl/bsfb_core.sv
// bsfb_core: bit, shift, flag and branch execution unit with its own
// working registers, io registers, program counter and status flags.
// Assumes a single AHB-Lite master; only whole-word single transfers.
`timescale 1ns/1ps
module bsfb_core #(
	parameter int K_W  = 7,  // branch offset width
	parameter int PC_W = 16, // program counter width
	parameter int NREG = 32, // working registers
	parameter int NIO  = 32  // io registers
) (
	input  wire logic        clk_i,       // core clock
	input  wire logic        rst_i,       // async reset, active high
	input  wire logic        hsel_i,      // slave select
	input  wire logic [31:0] haddr_i,     // byte address
	input  wire logic [1:0]  htrans_i,    // transfer type
	input  wire logic        hwrite_i,    // write not read
	input  wire logic [2:0]  hsize_i,     // word only
	input  wire logic [31:0] hwdata_i,    // write data
	input  wire logic        hready_i,    // bus ready
	output logic             hreadyout_o, // slave ready
	output logic      [31:0] hrdata_o,    // read data
	output logic             hresp_o,     // always okay
	output logic             busy_o       // command in progress
);
	localparam int RI_W = $clog2(NREG);
	localparam int IO_W = $clog2(NIO);
	localparam logic [PC_W-1:0] PC_ONE = 1;

	if (K_W < 2 || K_W > PC_W || NREG < 2 || NREG > 32 || NIO < 2 || NIO > 32 ||
		PC_W > 32 || (NREG & (NREG - 1)) != 0 || (NIO & (NIO - 1)) != 0) begin : g_chk
		$error("bsfb_core: unsupported parameter values");
	end

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_FIN  = 3'b100
	} bsfb_state_t;

	function automatic logic [PC_W-1:0] branch_target(input logic [PC_W-1:0] pc,
		input logic [K_W-1:0] k);
		branch_target = pc + {{(PC_W-K_W){k[K_W-1]}}, k} + PC_ONE;
	endfunction : branch_target

	function automatic logic is_io_op(input bsfb_pkg::bsfb_op_t op);
		is_io_op = (op == bsfb_pkg::op_set_io_bit) || (op == bsfb_pkg::op_clear_io_bit);
	endfunction : is_io_op

	bsfb_state_t                       st_r;
	bsfb_state_t                       st_nxt;
	logic                              ph_vld_r;
	logic                              ph_wr_r;
	logic [bsfb_pkg::ADDR_W-1:0]       ph_addr_r;
	bsfb_pkg::bsfb_op_t                op_r;
	logic [RI_W-1:0]                   idx_r;
	logic [IO_W-1:0]                   iox_r;
	logic [2:0]                        bit_r;
	logic [K_W-1:0]                    k_r;
	logic [PC_W-1:0]                   pc_r;
	logic [PC_W-1:0]                   tgt_r;
	logic                              taken_r;
	logic [7:0]                        flags_r;
	logic [7:0]                        wreg_r [NREG];
	logic [7:0]                        io_r   [NIO];
	logic [7:0]                        io_hold_r;
	logic                              lost_r;
	logic [1:0]                        cyc_r;
	logic [31:0]                       rd_w;
	logic                              wr_w;
	logic                              go_w;
	logic                              exec_w;
	logic                              fin_w;
	logic                              taken_w;
	logic                              two_w;
	logic [7:0]                        opnd_w;
	logic [7:0]                        res_w;
	logic [7:0]                        flags_w;
	logic                              ures_wr_w;
	logic [PC_W-1:0]                   tgt_w;
	logic                              wreg_hit_w;
	logic                              io_hit_w;
	logic [RI_W-1:0]                   bus_ri_w;
	logic [IO_W-1:0]                   bus_io_w;

	// bus side: one wait state per transfer, data phase acted on after capture
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ph_vld_r    <= 1'b0;
			ph_wr_r     <= 1'b0;
			ph_addr_r   <= '0;
			hreadyout_o <= 1'b1;
		end else begin
			ph_vld_r    <= hsel_i & htrans_i[1] & hready_i;
			hreadyout_o <= ~(hsel_i & htrans_i[1] & hready_i);
			if (hsel_i & htrans_i[1] & hready_i) begin
				ph_wr_r   <= hwrite_i;
				ph_addr_r <= haddr_i[bsfb_pkg::ADDR_W-1:0];
			end
		end
	end

	assign wr_w       = ph_vld_r & ph_wr_r;
	assign bus_ri_w   = ph_addr_r[2 +: RI_W];
	assign bus_io_w   = ph_addr_r[2 +: IO_W];
	assign wreg_hit_w = (ph_addr_r[bsfb_pkg::ADDR_W-1:bsfb_pkg::WIN_LSB] == bsfb_pkg::TAG_WREG) &&
		(ph_addr_r[bsfb_pkg::WIN_LSB-1:2] < 6'(NREG)) && (ph_addr_r[1:0] == 2'h0);
	assign io_hit_w   = (ph_addr_r[bsfb_pkg::ADDR_W-1:bsfb_pkg::WIN_LSB] == bsfb_pkg::TAG_IO) &&
		(ph_addr_r[bsfb_pkg::WIN_LSB-1:2] < 6'(NIO)) && (ph_addr_r[1:0] == 2'h0);

	always_comb begin
		rd_w = 32'h0000_0000;
		if (wreg_hit_w) rd_w[7:0] = wreg_r[bus_ri_w];
		else if (io_hit_w) rd_w[7:0] = io_r[bus_io_w];
		else begin
			unique case (ph_addr_r)
				bsfb_pkg::A_CMD: begin
					rd_w[bsfb_pkg::CMD_OP_LSB +: bsfb_pkg::OP_W] = op_r;
					rd_w[bsfb_pkg::CMD_IDX_LSB +: RI_W]          = idx_r;
					rd_w[bsfb_pkg::CMD_BIT_LSB +: 3]             = bit_r;
					rd_w[bsfb_pkg::CMD_IO_LSB +: IO_W]           = iox_r;
				end
				bsfb_pkg::A_KOFF:  rd_w[K_W-1:0]  = k_r;
				bsfb_pkg::A_PC:    rd_w[PC_W-1:0] = pc_r;
				bsfb_pkg::A_FLAGS: rd_w[7:0]      = flags_r;
				bsfb_pkg::A_STAT: begin
					rd_w[bsfb_pkg::ST_BUSY]       = (st_r != ST_IDLE);
					rd_w[bsfb_pkg::ST_LOST]       = lost_r;
					rd_w[bsfb_pkg::ST_CYC +: 2]   = cyc_r;
					rd_w[bsfb_pkg::ST_TAKEN]      = taken_r;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hrdata_o <= 32'h0000_0000;
			hresp_o  <= 1'b0;
		end else begin
			hresp_o <= 1'b0;
			if (ph_vld_r & ~ph_wr_r) hrdata_o <= rd_w;
		end
	end

	// command sequencing
	assign go_w    = wr_w && (ph_addr_r == bsfb_pkg::A_CMD) && (st_r == ST_IDLE);
	assign exec_w  = (st_r == ST_EXEC);
	assign fin_w   = (st_r == ST_FIN);
	assign taken_w = ((op_r == bsfb_pkg::op_branch_no_overflow) && !flags_r[bsfb_pkg::FL_V]) ||
		((op_r == bsfb_pkg::op_branch_irq_enabled) && flags_r[bsfb_pkg::FL_I]) ||
		((op_r == bsfb_pkg::op_branch_irq_disabled) && !flags_r[bsfb_pkg::FL_I]);
	assign two_w   = taken_w || is_io_op(op_r);
	assign tgt_w   = branch_target(pc_r, k_r);
	assign opnd_w  = is_io_op(op_r) ? io_r[iox_r] : wreg_r[idx_r];

	always_comb begin
		unique case (st_r)
			ST_IDLE: st_nxt = go_w ? ST_EXEC : ST_IDLE;
			ST_EXEC: st_nxt = two_w ? ST_FIN : ST_IDLE;
			ST_FIN:  st_nxt = ST_IDLE;
			default: st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r   <= ST_IDLE;
			busy_o <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			busy_o <= (st_nxt != ST_IDLE);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			op_r  <= bsfb_pkg::op_nop;
			idx_r <= '0;
			iox_r <= '0;
			bit_r <= 3'h0;
			k_r   <= '0;
		end else begin
			if (go_w) begin
				op_r  <= bsfb_pkg::bsfb_op_t'(hwdata_i[bsfb_pkg::CMD_OP_LSB +: bsfb_pkg::OP_W]);
				idx_r <= hwdata_i[bsfb_pkg::CMD_IDX_LSB +: RI_W];
				iox_r <= hwdata_i[bsfb_pkg::CMD_IO_LSB +: IO_W];
				bit_r <= hwdata_i[bsfb_pkg::CMD_BIT_LSB +: 3];
			end
			if (wr_w && (ph_addr_r == bsfb_pkg::A_KOFF)) k_r <= hwdata_i[K_W-1:0];
		end
	end

	// status: lost is sticky, write one to clear, a new loss wins
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lost_r  <= 1'b0;
			cyc_r   <= 2'h0;
			taken_r <= 1'b0;
			tgt_r   <= '0;
		end else begin
			if (wr_w && (ph_addr_r == bsfb_pkg::A_CMD) && (st_r != ST_IDLE)) lost_r <= 1'b1;
			else if (wr_w && (ph_addr_r == bsfb_pkg::A_STAT) && hwdata_i[bsfb_pkg::ST_LOST])
				lost_r <= 1'b0;
			if (exec_w) begin
				taken_r <= taken_w;
				tgt_r   <= tgt_w;
				cyc_r   <= two_w ? bsfb_pkg::CYC_TWO : bsfb_pkg::CYC_ONE;
			end
		end
	end

	// program counter: execution has priority over a bus write
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) pc_r <= '0;
		else if (exec_w && !two_w) pc_r <= pc_r + PC_ONE;
		else if (fin_w) pc_r <= taken_r ? tgt_r : pc_r + PC_ONE;
		else if (wr_w && (ph_addr_r == bsfb_pkg::A_PC)) pc_r <= hwdata_i[PC_W-1:0];
	end

	bsfb_exec_unit u_exec (
		.op_i    (op_r),
		.opnd_i  (opnd_w),
		.bit_i   (bit_r),
		.flags_i (flags_r),
		.res_o   (res_w),
		.flags_o (flags_w),
		.wr_o    (ures_wr_w)
	);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) flags_r <= bsfb_pkg::FLAGS_RST;
		else if (exec_w) flags_r <= flags_w;
		else if (wr_w && (ph_addr_r == bsfb_pkg::A_FLAGS)) flags_r <= hwdata_i[7:0];
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < NREG; i++) wreg_r[i] <= 8'h00;
		end else if (exec_w && ures_wr_w && !is_io_op(op_r)) begin
			wreg_r[idx_r] <= res_w;
		end else if (wr_w && wreg_hit_w) begin
			wreg_r[bus_ri_w] <= hwdata_i[7:0];
		end
	end

	// io bit ops read in the first cycle and write back in the second
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			io_hold_r <= 8'h00;
			for (int i = 0; i < NIO; i++) io_r[i] <= 8'h00;
		end else begin
			if (exec_w) io_hold_r <= res_w;
			if (fin_w && is_io_op(op_r)) io_r[iox_r] <= io_hold_r;
			else if (wr_w && io_hit_w) io_r[bus_io_w] <= hwdata_i[7:0];
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic [7:0] dst_w;
	assign dst_w = wreg_r[idx_r];

	sequence s_two_step;
		fin_w ##1 (st_r == ST_IDLE);
	endsequence

	property p_no_ovf_taken;
		exec_w && op_r == bsfb_pkg::op_branch_no_overflow && !flags_r[bsfb_pkg::FL_V]
			|=> s_two_step and (##1 pc_r == $past(tgt_w, 2));
	endproperty
	a_no_ovf_taken: assert property (p_no_ovf_taken) else $error("overflow branch wrong");

	property p_irq_branch;
		exec_w && op_r == bsfb_pkg::op_branch_irq_enabled && !flags_r[bsfb_pkg::FL_I]
			|=> st_r == ST_IDLE && pc_r == $past(pc_r) + PC_ONE && $stable(flags_r);
	endproperty
	a_irq_branch: assert property (p_irq_branch) else $error("untaken branch wrong");

	property p_irq_off_taken;
		exec_w && op_r == bsfb_pkg::op_branch_irq_disabled && !flags_r[bsfb_pkg::FL_I]
			|-> ##2 pc_r == $past(tgt_w, 2);
	endproperty
	a_irq_off_taken: assert property (p_irq_off_taken) else $error("irq-off branch wrong");

	property p_io_set;
		exec_w && op_r == bsfb_pkg::op_set_io_bit
			|=> s_two_step and ($stable(flags_r) [*2]) and (##1 io_r[iox_r][bit_r] == 1'b1);
	endproperty
	a_io_set: assert property (p_io_set) else $error("io set bit wrong");

	property p_io_clear;
		fin_w && op_r == bsfb_pkg::op_clear_io_bit |=> io_r[iox_r] == $past(io_hold_r)
			&& !io_r[iox_r][bit_r];
	endproperty
	a_io_clear: assert property (p_io_clear) else $error("io clear bit wrong");

	property p_lsl;
		exec_w && op_r == bsfb_pkg::op_shift_left_logical |=> dst_w == 8'($past(opnd_w) << 1)
			&& flags_r[bsfb_pkg::FL_C] == $past(opnd_w[7]) && st_r == ST_IDLE;
	endproperty
	a_lsl: assert property (p_lsl) else $error("left shift wrong");

	property p_ror;
		exec_w && op_r == bsfb_pkg::op_rotate_right_carry |=> dst_w[7] ==
			$past(flags_r[bsfb_pkg::FL_C]) && flags_r[bsfb_pkg::FL_C] == $past(opnd_w[0]);
	endproperty
	a_ror: assert property (p_ror) else $error("right rotate wrong");

	property p_asr;
		exec_w && op_r == bsfb_pkg::op_shift_right_arithmetic
			|=> dst_w == {$past(opnd_w[7]), $past(opnd_w[7:1])};
	endproperty
	a_asr: assert property (p_asr) else $error("arithmetic shift wrong");

	property p_bst;
		exec_w && op_r == bsfb_pkg::op_store_bit_to_transfer_flag |=> flags_r[bsfb_pkg::FL_T]
			== $past(opnd_w[bit_r]) && flags_r[5:0] == $past(flags_r[5:0]);
	endproperty
	a_bst: assert property (p_bst) else $error("bit store wrong");

	property p_fset;
		exec_w && op_r == bsfb_pkg::op_flag_set |=> flags_r == ($past(flags_r) | (8'h01 << bit_r));
	endproperty
	a_fset: assert property (p_fset) else $error("flag set wrong");
endmodule : bsfb_core

// ===== verification/test_bsfb_core.sv
// test_bsfb_core: self-checking bench for the bit/shift/flag/branch core.
// Assumes the core is the only AHB-Lite slave, so hreadyout_o feeds hready_i.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
	$display("unexpected %s: expected %h, seen %h", nm, e, g); end end
module test_bsfb_core;
	logic        clk_i;
	logic        rst_i;
	logic        hsel_i;
	logic [31:0] haddr_i;
	logic [1:0]  htrans_i;
	logic        hwrite_i;
	logic [2:0]  hsize_i;
	logic [31:0] hwdata_i;
	logic        hready_i;
	logic        hreadyout_o;
	logic [31:0] hrdata_o;
	logic        hresp_o;
	logic        busy_o;
	int          errors;
	int          compares;
	int          cycles;
	int          busy_n;
	int          busy_last;
	logic [7:0]  vals [3] = '{8'h81, 8'h40, 8'h01};
	logic [7:0]  f;
	logic [15:0] ex;
	logic [6:0]  k;
	logic [15:0] tgt;

	assign hready_i = hreadyout_o;

	bsfb_core u_bsfb_core (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.hsel_i      (hsel_i),
		.haddr_i     (haddr_i),
		.htrans_i    (htrans_i),
		.hwrite_i    (hwrite_i),
		.hsize_i     (hsize_i),
		.hwdata_i    (hwdata_i),
		.hready_i    (hready_i),
		.hreadyout_o (hreadyout_o),
		.hrdata_o    (hrdata_o),
		.hresp_o     (hresp_o),
		.busy_o      (busy_o)
	);

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic report_and_stop;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	// a hang anywhere ends the run here
	always @(posedge clk_i) begin
		cycles++;
		if (busy_o === 1'b1) busy_n++;
		if (cycles == 20000) begin
			errors++;
			report_and_stop();
		end
	end

	// one single AHB transfer: address phase, then data phase, each held until hready
	task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
			output logic [31:0] q);
		hsel_i   <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i  <= {22'h0, a};
		hwrite_i <= wr;
		do @(posedge clk_i); while (hready_i !== 1'b1);
		hsel_i   <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge clk_i); while (hready_i !== 1'b1);
		q = hrdata_o;
	endtask : xfer

	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask : wr

	task automatic rdc(input string nm, input logic [9:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		`CHK(nm, e, q)
	endtask : rdc

	// start a command and poll until it has finished; busy_last counts the clock edges on which busy_o was high
	task automatic cmd(input logic [4:0] op, input logic [4:0] idx, input logic [2:0] b,
			input logic [4:0] io);
		logic [31:0] q;
		int          b0;
		b0 = busy_n;
		wr(bsfb_pkg::A_CMD, {3'h0, io, 5'h0, b, 3'h0, idx, 3'h0, op});
		do xfer(1'b0, bsfb_pkg::A_STAT, 32'h0, q); while (q[0] !== 1'b0);
		busy_last = busy_n - b0;
	endtask : cmd

	// expected {flags, result} of the one-operand ops
	function automatic logic [15:0] alu(input int op, input logic [7:0] v, input logic [7:0] fi);
		logic [7:0] r;
		logic [7:0] nf;
		logic       c;
		nf = fi;
		c  = fi[0];
		case (op)
			6: begin r = {v[6:0], 1'b0}; c = v[7]; end
			7: begin r = {1'b0, v[7:1]}; c = v[0]; end
			8: begin r = {v[6:0], fi[0]}; c = v[7]; end
			9: begin r = {fi[0], v[7:1]}; c = v[0]; end
			10: begin r = {v[7], v[7:1]}; c = v[0]; end
			default: r = {v[3:0], v[7:4]};
		endcase
		if (op != 11) begin
			nf[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
		end
		return {nf, r};
	endfunction : alu

	initial begin
		rst_i    = 1'b1;
		hsel_i   = 1'b0;
		haddr_i  = 32'h0;
		htrans_i = 2'h0;
		hwrite_i = 1'b0;
		hsize_i  = 3'h2;
		hwdata_i = 32'h0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc("pc", bsfb_pkg::A_PC, 32'h0);
		rdc("flags", bsfb_pkg::A_FLAGS, 32'h0);
		rdc("stat", bsfb_pkg::A_STAT, 32'h0);
		$display("test reset done");

		for (int op = 6; op <= 11; op++) begin
			for (int i = 0; i < 3; i++) begin
				f  = 8'h70 | {7'h0, i[0]};
				ex = alu(op, vals[i], f);
				wr(bsfb_pkg::A_FLAGS, {24'h0, f});
				wr(10'h114, {24'h0, vals[i]});
				wr(bsfb_pkg::A_PC, 32'h10);
				cmd(op[4:0], 5'h5, 3'h0, 5'h0);
				`CHK("shift cycles", 1, busy_last)
				rdc("shift result", 10'h114, {24'h0, ex[7:0]});
				rdc("shift flags", bsfb_pkg::A_FLAGS, {24'h0, ex[15:8]});
				rdc("shift pc", bsfb_pkg::A_PC, 32'h11);
				rdc("shift stat", bsfb_pkg::A_STAT, 32'h4);
			end
		end
		$display("test shifts done");

		for (int s = 0; s < 8; s++) begin
			wr(bsfb_pkg::A_FLAGS, 32'h0);
			cmd(5'h0E, 5'h0, s[2:0], 5'h0);
			rdc("flag set", bsfb_pkg::A_FLAGS, 32'h1 << s);
			wr(bsfb_pkg::A_FLAGS, 32'hFF);
			cmd(5'h0F, 5'h0, s[2:0], 5'h0);
			rdc("flag clear", bsfb_pkg::A_FLAGS, 32'hFF ^ (32'h1 << s));
			`CHK("flag cycles", 1, busy_last)
			rdc("flag stat", bsfb_pkg::A_STAT, 32'h4);
		end
		$display("test flags done");

		wr(bsfb_pkg::A_FLAGS, 32'h0);
		wr(10'h10C, 32'h20);
		cmd(5'h0C, 5'h3, 3'h5, 5'h0);
		rdc("t store one", bsfb_pkg::A_FLAGS, 32'h40);
		cmd(5'h0C, 5'h3, 3'h4, 5'h0);
		rdc("t store zero", bsfb_pkg::A_FLAGS, 32'h0);
		`CHK("t store cycles", 1, busy_last)
		wr(bsfb_pkg::A_FLAGS, 32'h4F);
		wr(10'h110, 32'h81);
		cmd(5'h0D, 5'h4, 3'h2, 5'h0);
		rdc("t load one", 10'h110, 32'h85);
		rdc("t load flags", bsfb_pkg::A_FLAGS, 32'h4F);
		wr(bsfb_pkg::A_FLAGS, 32'h0F);
		cmd(5'h0D, 5'h4, 3'h7, 5'h0);
		rdc("t load zero", 10'h110, 32'h05);
		`CHK("t load cycles", 1, busy_last)
		$display("test transfer flag done");

		wr(bsfb_pkg::A_FLAGS, 32'h2A);
		wr(10'h21C, 32'hA5);
		wr(10'h220, 32'h5A);
		cmd(5'h04, 5'h0, 3'h1, 5'h7);
		rdc("io set", 10'h21C, 32'hA7);
		rdc("io set stat", bsfb_pkg::A_STAT, 32'h8);
		`CHK("io set cycles", 2, busy_last)
		cmd(5'h05, 5'h0, 3'h0, 5'h7);
		rdc("io clear", 10'h21C, 32'hA6);
		rdc("io clear stat", bsfb_pkg::A_STAT, 32'h8);
		`CHK("io clear cycles", 2, busy_last)
		rdc("io neighbour", 10'h220, 32'h5A);
		rdc("io flags", bsfb_pkg::A_FLAGS, 32'h2A);
		$display("test io bits done");

		for (int b = 0; b < 3; b++) begin
			for (int t = 0; t < 2; t++) begin
				k   = (b == 0) ? 7'h7E : ((b == 1) ? 7'h3F : 7'h40);
				tgt = 16'h0100 + {{9{k[6]}}, k} + 16'h1;
				f   = (b == 0) ? (t == 1 ? 8'h00 : 8'h08) :
					(b == 1) ? (t == 1 ? 8'h80 : 8'h00) : (t == 1 ? 8'h00 : 8'h80);
				f   = f | 8'h21;
				wr(bsfb_pkg::A_KOFF, {25'h0, k});
				wr(bsfb_pkg::A_PC, 32'h100);
				wr(bsfb_pkg::A_FLAGS, {24'h0, f});
				cmd(5'(b + 1), 5'h0, 3'h0, 5'h0);
				rdc("branch pc", bsfb_pkg::A_PC, t == 1 ? {16'h0, tgt} : 32'h101);
				rdc("branch flags", bsfb_pkg::A_FLAGS, {24'h0, f});
				rdc("branch stat", bsfb_pkg::A_STAT, t == 1 ? 32'h18 : 32'h4);
				`CHK("branch cycles", t + 1, busy_last)
			end
		end
		$display("test branches done");

		wr(10'h3FC, 32'hFFFFFFFF);
		rdc("unmapped", 10'h3FC, 32'h0);
		`CHK("resp", 1'b0, hresp_o)
		$display("test unmapped done");
		report_and_stop();
	end
endmodule : test_bsfb_core
